// >>> pvic_pkg.sv
// Constants, register map and field layout of the vectored interrupt controller
package pvic_pkg;

   // ==========================================================
   // Geometry
   localparam int NSRC = 80;                    // User sources, vectors 8..87
   localparam int NTRAP = 5;                    // Trap vectors 1..5
   localparam logic [6:0] FIRST_USER_VEC = 7'h08;
   localparam logic [6:0] LAST_USER_VEC = 7'h57;
   localparam int PRIO_W = 3;
   localparam int SRC_PER_PRIO_REG = 4;

   // ==========================================================
   // Vector tables
   localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
   localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CPU_STATUS_WORD_OFS = 8'h00;
   localparam logic [7:0] CORE_CONTROL_WORD_OFS = 8'h04;
   localparam logic [7:0] GLOBAL_CTRL_ONE_OFS = 8'h08;
   localparam logic [7:0] GLOBAL_CTRL_TWO_OFS = 8'h0c;
   localparam logic [7:0] PENDING_VECTOR_OFS = 8'h10;
   localparam logic [7:0] REQUEST_FLAG_BANK_OFS = 8'h20;
   localparam logic [7:0] SOURCE_ENABLE_BANK_OFS = 8'h40;
   localparam logic [7:0] SOURCE_PRIORITY_BANK_OFS = 8'h80;
   localparam logic [5:0] FLAG_REGS = 6'h05;
   localparam logic [5:0] PRIO_REGS = 6'h14;

   // ==========================================================
   // Field positions
   localparam int SR_LEVEL_LSB = 5;
   localparam int CORE_CONTROL_WORD_LEVEL_MSB_BIT = 3;
   localparam int IC1_NESTING_DISABLE = 15;
   localparam int IC1_ACC_A_OVF = 14;
   localparam int IC1_ACC_B_OVF = 13;
   localparam int IC1_ACC_A_CAT = 12;
   localparam int IC1_ACC_B_CAT = 11;
   localparam int IC1_ACC_A_OVF_TE = 10;
   localparam int IC1_ACC_B_OVF_TE = 9;
   localparam int IC1_CAT_TE = 8;
   localparam int IC1_BAD_SHIFT = 7;
   localparam int IC1_ZERO_DIVIDE = 6;
   localparam int IC1_TRAP_LSB = 1;             // Bits 5:1 trap status, vectors 1..5
   localparam int IC1_MATH_TRAP = 4;
   localparam int IC2_ALT_TABLE = 15;
   localparam logic [15:0] IC1_MASK = 16'hfffe;
   localparam logic [15:0] IC2_MASK = 16'h8007;

   // ==========================================================
   // Reset values
   localparam logic [15:0] IC1_RESET = 16'h0000;
   localparam logic [15:0] IC2_RESET = 16'h0000;
   localparam logic [2:0] LEVEL_RESET = 3'h0;

   // ==========================================================
   // Trap levels, index 0 is vector 1; all sit above the user range
   localparam logic [3:0] TRAP_LEVEL [NTRAP] = '{4'he, 4'hd, 4'hc, 4'hb, 4'ha};

   // External request sources, as indices into the user banks
   localparam int EXT_IDX0 = 0;
   localparam int EXT_IDX1 = 20;
   localparam int EXT_IDX2 = 29;

   // Unlisted vectors have no flag or enable storage; their priority bits are still stored
   function automatic logic [NSRC-1:0] pvic_impl_mask();
      logic [NSRC-1:0] m;
      m = '1;
      for (int v = 8; v < 88; v++) begin
         if (v == 23 || v == 29 || (v >= 45 && v <= 52) || (v >= 55 && v <= 66) ||
             v == 71 || v == 72 || (v >= 79 && v <= 85)) begin
            m[v-8] = 1'b0;
         end
      end
      return m;
   endfunction : pvic_impl_mask

endpackage : pvic_pkg

// >>> pvic_arbiter.sv
// Priority resolver for the user sources: highest level, then lowest vector
`timescale 1ns/10ps
module pvic_arbiter #(
   parameter int N = 80
) (
   input wire logic [N-1:0] req,                // Flag and enable both set
   input wire logic [N*3-1:0] prio,             // Three-bit level per source
   input wire logic [3:0] cpu_level,            // Effective CPU level
   output logic hit,                            // A source beats the CPU level
   output logic [6:0] idx,                      // Winning source index
   output logic [2:0] level                     // Winning source level
);
   import pvic_pkg::*;

   logic [2:0] p;

   always_comb begin
      hit = 1'b0;
      idx = 7'h00;
      level = 3'h0;
      p = 3'h0;
      // Scan downward with >= so that equal levels leave the lowest index standing
      for (int i = N - 1; i >= 0; i--) begin
         p = prio[i*3 +: 3];
         if (req[i] && ({1'b0, p} > cpu_level) && (!hit || p >= level)) begin
            hit = 1'b1;
            idx = 7'(i);
            level = p;
         end
      end
      // Level msb set or seven in the low bits blocks every user source
      if (cpu_level[3] || cpu_level[2:0] == 3'h7) begin
         hit = 1'b0;
      end
   end

endmodule : pvic_arbiter

// >>> pvic_ctrl.sv
// Vectored interrupt controller with AXI4-Lite register access
//
// Function
// - Trap vectors 1..5 in primary table; vectors 0, 6, 7 reserved.
// - Alternate table mirrors primary, each entry 0x100 higher.
// - Each source owns a fixed vector, 8 to 87; unlisted ones reserved.
// - Control, flag, enable, priority banks and pending-vector register are provided.
// - Second control register sets external edge polarity and table select.
// - Hardware sets request flags; software clears them.
// - A source with clear enable never requests the CPU.
// - Each user source has a three-bit priority, eight levels.
// - Pending vector number and level latched in pending register.
// - Latched level equals priority of the presented interrupt.
// - Bank bit positions follow vector order, vector 8 at bit 0.
// - Low three CPU level bits sit in status word bits 7:5.
// - Software may write the status level bits unless nesting disabled.
// - Level msb in core control bit 3: readable, clearable, never settable by software.
// - Effective level is msb over three bits; msb or 111 blocks users.
// - Nesting disable makes the status level bits read-only.
// - Bits 14 and 13 flag accumulator A and B overflow traps.
// - Bits 12 and 11 flag catastrophic A and B overflow traps.
// - Bits 10, 9, 8 arm overflow A, overflow B, catastrophic traps.
// - Bit 7 flags a math trap from an invalid accumulator shift.
// - Bit 6 flags a math trap from division by zero.
// - Table select set fetches every vector from the alternate table.
// - Equal priorities resolve by natural order, lower vector wins.
// - Each external input has polarity: set means negative edge.
`timescale 1ns/10ps
module pvic_ctrl #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,                       // 200 MHz clock
   input wire logic aresetn,                    // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
   input wire logic s_axi_awvalid,              // Write address valid
   output logic s_axi_awready,                  // Write address ready
   input wire logic [31:0] s_axi_wdata,         // Write data
   input wire logic [3:0] s_axi_wstrb,          // Write byte strobes
   input wire logic s_axi_wvalid,               // Write data valid
   output logic s_axi_wready,                   // Write data ready
   output logic [1:0] s_axi_bresp,              // Write response
   output logic s_axi_bvalid,                   // Write response valid
   input wire logic s_axi_bready,               // Write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
   input wire logic s_axi_arvalid,              // Read address valid
   output logic s_axi_arready,                  // Read address ready
   output logic [31:0] s_axi_rdata,             // Read data
   output logic [1:0] s_axi_rresp,              // Read response
   output logic s_axi_rvalid,                   // Read data valid
   input wire logic s_axi_rready,               // Read data ready
   input wire logic [pvic_pkg::NSRC-1:0] src_req, // Peripheral set pulses, bit 0 = vector 8
   input wire logic [2:0] ext_irq,              // External request pins 0..2
   input wire logic [pvic_pkg::NTRAP-1:0] trap_evt, // Trap events, bit 0 = vector 1
   input wire logic math_ovf_a,                 // Accumulator A overflow
   input wire logic math_ovf_b,                 // Accumulator B overflow
   input wire logic math_cat_a,                 // Accumulator A catastrophic overflow
   input wire logic math_cat_b,                 // Accumulator B catastrophic overflow
   input wire logic math_bad_shift,             // Invalid accumulator shift
   input wire logic math_zero_div,              // Divide by zero
   input wire logic irq_ack,                    // CPU takes the presented interrupt
   output logic irq_req,                        // Request to the CPU
   output logic [6:0] irq_vector,               // Presented vector number
   output logic [3:0] irq_level,                // Presented level
   output logic [23:0] irq_addr,                // Vector slot address in program memory
   output logic [3:0] cpu_level                 // Effective CPU level
);
   import pvic_pkg::*;

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic [NSRC-1:0] IMPL = pvic_impl_mask();

   typedef struct packed {
      logic aw_hold;
      logic [ADDR_W-1:0] awaddr;
      logic w_hold;
      logic [15:0] wdata;
      logic [1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [15:0] rdata;
      logic [1:0] rresp;
      logic [2:0] level_low;
      logic level_msb;
      logic [15:0] ic1;
      logic [15:0] ic2;
      logic [2:0] ext_prev;
      logic [NSRC-1:0] flags;
      logic [NSRC-1:0] enables;
      logic [NSRC*PRIO_W-1:0] prio;
      logic pend;
      logic [6:0] pend_vec;
      logic [3:0] pend_lvl;
      logic [23:0] pend_addr;
   } pvic_state_t;

   pvic_state_t st_reg;
   pvic_state_t st_next;

   // ==========================================================
   // Helpers
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
                                           input logic [1:0] strb);
      merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   // Word index inside a bank, or all ones when the address misses it
   function automatic logic [5:0] bank_index(input logic [ADDR_W-1:0] a,
                                             input logic [7:0] base, input logic [5:0] cnt);
      logic [7:0] d;
      d = 8'(a) - base;
      if (a >= ADDR_W'(base) && d[1:0] == 2'b00 && d[7:2] < cnt) begin
         bank_index = d[7:2];
      end else begin
         bank_index = 6'h3f;
      end
   endfunction : bank_index

   function automatic logic [15:0] prio_word(input logic [NSRC*PRIO_W-1:0] p,
                                             input logic [5:0] k);
      prio_word = '0;
      for (int j = 0; j < SRC_PER_PRIO_REG; j++) begin
         prio_word[j*4 +: 3] = p[(int'(k) * SRC_PER_PRIO_REG + j) * PRIO_W +: PRIO_W];
      end
   endfunction : prio_word

   // Full register read; miss reports an error and zero data
   function automatic logic [16:0] read_reg(input pvic_state_t s, input logic [ADDR_W-1:0] a);
      logic [5:0] fi;
      logic [5:0] ei;
      logic [5:0] pi;
      fi = bank_index(a, REQUEST_FLAG_BANK_OFS, FLAG_REGS);
      ei = bank_index(a, SOURCE_ENABLE_BANK_OFS, FLAG_REGS);
      pi = bank_index(a, SOURCE_PRIORITY_BANK_OFS, PRIO_REGS);
      read_reg = {1'b1, 16'h0000};
      if (a == ADDR_W'(CPU_STATUS_WORD_OFS)) begin
         read_reg = {1'b0, 16'(s.level_low) << SR_LEVEL_LSB};
      end else if (a == ADDR_W'(CORE_CONTROL_WORD_OFS)) begin
         read_reg = {1'b0, 16'(s.level_msb) << CORE_CONTROL_WORD_LEVEL_MSB_BIT};
      end else if (a == ADDR_W'(GLOBAL_CTRL_ONE_OFS)) begin
         read_reg = {1'b0, s.ic1 & IC1_MASK};
      end else if (a == ADDR_W'(GLOBAL_CTRL_TWO_OFS)) begin
         read_reg = {1'b0, s.ic2 & IC2_MASK};
      end else if (a == ADDR_W'(PENDING_VECTOR_OFS)) begin
         read_reg = {1'b0, 4'h0, s.pend_lvl, 1'b0, s.pend_vec};
      end else if (fi != 6'h3f) begin
         read_reg = {1'b0, s.flags[int'(fi)*16 +: 16]};
      end else if (ei != 6'h3f) begin
         read_reg = {1'b0, s.enables[int'(ei)*16 +: 16]};
      end else if (pi != 6'h3f) begin
         read_reg = {1'b0, prio_word(s.prio, pi)};
      end
   endfunction : read_reg

   // ==========================================================
   // Arbitration
   logic [3:0] eff_level;
   logic user_hit;
   logic [6:0] user_idx;
   logic [2:0] user_lvl;

   assign eff_level = {st_reg.level_msb, st_reg.level_low};

   pvic_arbiter #(
      .N(NSRC)
   ) u_arb (
      .req(st_reg.flags & st_reg.enables & IMPL),
      .prio(st_reg.prio),
      .cpu_level(eff_level),
      .hit(user_hit),
      .idx(user_idx),
      .level(user_lvl)
   );

   // ==========================================================
   // Next state
   logic wr_fire;
   logic [15:0] wd;
   logic [5:0] wfi;
   logic [5:0] wei;
   logic [5:0] wpi;
   logic wr_hit;
   logic [NSRC-1:0] hw_set;
   logic [2:0] ext_edge;
   logic [NTRAP-1:0] trap_set;
   logic math_fire;
   logic trap_hit;
   logic [6:0] win_vec;
   logic [3:0] win_lvl;
   logic [16:0] rd;

   always_comb begin
      st_next = st_reg;
      wr_fire = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
      wfi = bank_index(st_reg.awaddr, REQUEST_FLAG_BANK_OFS, FLAG_REGS);
      wei = bank_index(st_reg.awaddr, SOURCE_ENABLE_BANK_OFS, FLAG_REGS);
      wpi = bank_index(st_reg.awaddr, SOURCE_PRIORITY_BANK_OFS, PRIO_REGS);
      wd = 16'h0000;
      wr_hit = 1'b0;
      rd = read_reg(st_reg, s_axi_araddr);
      ext_edge = 3'h0;
      trap_set = trap_evt;
      math_fire = 1'b0;
      trap_hit = 1'b0;
      win_vec = 7'h00;
      win_lvl = 4'h0;

      // ---- Bus handshakes
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_hold = 1'b1;
         st_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_hold = 1'b1;
         st_next.wdata = s_axi_wdata[15:0];
         st_next.wstrb = s_axi_wstrb[1:0];
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         st_next.rvalid = 1'b1;
         st_next.rdata = rd[15:0];
         st_next.rresp = rd[16] ? RESP_SLVERR : RESP_OKAY;
      end

      // ---- Software writes; hardware sets below take precedence
      if (wr_fire) begin
         st_next.aw_hold = 1'b0;
         st_next.w_hold = 1'b0;
         st_next.bvalid = 1'b1;
         wr_hit = 1'b1;
         if (st_reg.awaddr == ADDR_W'(CPU_STATUS_WORD_OFS)) begin
            wd = merge16(16'(st_reg.level_low) << SR_LEVEL_LSB, st_reg.wdata, st_reg.wstrb);
            if (!st_reg.ic1[IC1_NESTING_DISABLE]) begin
               st_next.level_low = wd[SR_LEVEL_LSB +: 3];
            end
         end else if (st_reg.awaddr == ADDR_W'(CORE_CONTROL_WORD_OFS)) begin
            wd = merge16(16'(st_reg.level_msb) << CORE_CONTROL_WORD_LEVEL_MSB_BIT, st_reg.wdata,
                         st_reg.wstrb);
            st_next.level_msb = st_reg.level_msb & wd[CORE_CONTROL_WORD_LEVEL_MSB_BIT];
         end else if (st_reg.awaddr == ADDR_W'(GLOBAL_CTRL_ONE_OFS)) begin
            st_next.ic1 = merge16(st_reg.ic1, st_reg.wdata, st_reg.wstrb) & IC1_MASK;
         end else if (st_reg.awaddr == ADDR_W'(GLOBAL_CTRL_TWO_OFS)) begin
            st_next.ic2 = merge16(st_reg.ic2, st_reg.wdata, st_reg.wstrb) & IC2_MASK;
         end else if (st_reg.awaddr == ADDR_W'(PENDING_VECTOR_OFS)) begin
            wr_hit = 1'b1;
         end else if (wfi != 6'h3f) begin
            wd = merge16(st_reg.flags[int'(wfi)*16 +: 16], st_reg.wdata, st_reg.wstrb);
            st_next.flags[int'(wfi)*16 +: 16] = wd & IMPL[int'(wfi)*16 +: 16];
         end else if (wei != 6'h3f) begin
            wd = merge16(st_reg.enables[int'(wei)*16 +: 16], st_reg.wdata, st_reg.wstrb);
            st_next.enables[int'(wei)*16 +: 16] = wd & IMPL[int'(wei)*16 +: 16];
         end else if (wpi != 6'h3f) begin
            wd = merge16(prio_word(st_reg.prio, wpi), st_reg.wdata, st_reg.wstrb);
            for (int j = 0; j < SRC_PER_PRIO_REG; j++) begin
               st_next.prio[(int'(wpi) * SRC_PER_PRIO_REG + j) * PRIO_W +: PRIO_W] =
                  wd[j*4 +: 3];
            end
         end else begin
            wr_hit = 1'b0;
         end
         st_next.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end

      // ---- External pins, edge chosen per pin
      for (int k = 0; k < 3; k++) begin
         ext_edge[k] = st_reg.ic2[k] ? (st_reg.ext_prev[k] && !ext_irq[k])
                                     : (!st_reg.ext_prev[k] && ext_irq[k]);
      end
      st_next.ext_prev = ext_irq;
      hw_set = src_req;
      hw_set[EXT_IDX0] = hw_set[EXT_IDX0] | ext_edge[0];
      hw_set[EXT_IDX1] = hw_set[EXT_IDX1] | ext_edge[1];
      hw_set[EXT_IDX2] = hw_set[EXT_IDX2] | ext_edge[2];
      st_next.flags = st_next.flags | (hw_set & IMPL);

      // ---- Math trap causes, only armed overflow kinds trap
      if (math_ovf_a && st_reg.ic1[IC1_ACC_A_OVF_TE]) begin
         st_next.ic1[IC1_ACC_A_OVF] = 1'b1;
         math_fire = 1'b1;
      end
      if (math_ovf_b && st_reg.ic1[IC1_ACC_B_OVF_TE]) begin
         st_next.ic1[IC1_ACC_B_OVF] = 1'b1;
         math_fire = 1'b1;
      end
      if (math_cat_a && st_reg.ic1[IC1_CAT_TE]) begin
         st_next.ic1[IC1_ACC_A_CAT] = 1'b1;
         math_fire = 1'b1;
      end
      if (math_cat_b && st_reg.ic1[IC1_CAT_TE]) begin
         st_next.ic1[IC1_ACC_B_CAT] = 1'b1;
         math_fire = 1'b1;
      end
      if (math_bad_shift) begin
         st_next.ic1[IC1_BAD_SHIFT] = 1'b1;
         math_fire = 1'b1;
      end
      if (math_zero_div) begin
         st_next.ic1[IC1_ZERO_DIVIDE] = 1'b1;
         math_fire = 1'b1;
      end
      trap_set[IC1_MATH_TRAP - IC1_TRAP_LSB] = trap_set[IC1_MATH_TRAP - IC1_TRAP_LSB] |
                                                math_fire;
      st_next.ic1[IC1_TRAP_LSB +: NTRAP] = st_next.ic1[IC1_TRAP_LSB +: NTRAP] | trap_set;

      // ---- Winner: traps ignore enables and CPU level, lowest vector first
      for (int t = NTRAP - 1; t >= 0; t--) begin
         if (st_reg.ic1[IC1_TRAP_LSB + t]) begin
            trap_hit = 1'b1;
            win_vec = 7'(t + 1);
            win_lvl = TRAP_LEVEL[t];
         end
      end
      if (!trap_hit && user_hit) begin
         win_vec = FIRST_USER_VEC + user_idx;
         win_lvl = {1'b0, user_lvl};
      end
      st_next.pend = trap_hit || user_hit;
      if (trap_hit || user_hit) begin
         st_next.pend_vec = win_vec;
         st_next.pend_lvl = win_lvl;
         // Slot address follows the table select at the moment of latching
         st_next.pend_addr = PRIMARY_TABLE_BASE + (24'(win_vec) << 1) +
                             (st_reg.ic2[IC2_ALT_TABLE] ? ALT_TABLE_OFFSET : 24'h000000);
      end

      // ---- Acceptance sets the CPU level to the presented one
      if (irq_ack && st_reg.pend) begin
         st_next.level_low = st_reg.pend_lvl[2:0];
         st_next.level_msb = st_reg.pend_lvl[3];
      end

      if (!aresetn) begin
         st_next = '0;
         st_next.ic1 = IC1_RESET;
         st_next.ic2 = IC2_RESET;
         st_next.level_low = LEVEL_RESET;
      end
   end

   always_ff @(posedge aclk) begin
      st_reg <= st_next;
   end

   // ==========================================================
   // Outputs
   assign s_axi_awready = !st_reg.aw_hold && !st_reg.bvalid;
   assign s_axi_wready = !st_reg.w_hold && !st_reg.bvalid;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = {16'h0000, st_reg.rdata};
   assign s_axi_rresp = st_reg.rresp;
   assign irq_req = st_reg.pend;
   assign irq_vector = st_reg.pend_vec;
   assign irq_level = st_reg.pend_lvl;
   assign irq_addr = st_reg.pend_addr;
   assign cpu_level = eff_level;

endmodule : pvic_ctrl

// >>> pvic_checker.sv
// Port-level assertions for the vectored interrupt controller
`timescale 1ns/10ps
module pvic_checker (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic s_axi_awready, // Ready
   input wire logic s_axi_wready, // Ready
   input wire logic [1:0] s_axi_bresp, // Response
   input wire logic s_axi_bvalid, // Valid
   input wire logic s_axi_bready, // Ready
   input wire logic [pvic_pkg::NTRAP-1:0] trap_evt, // Traps
   input wire logic irq_ack, // Taken
   input wire logic irq_req, // Request
   input wire logic [6:0] irq_vector, // Vector
   input wire logic [3:0] irq_level, // Level
   input wire logic [23:0] irq_addr, // Slot
   input wire logic [3:0] cpu_level // CPU level
);
   import pvic_pkg::*;
   // ==========================================================
   // Checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response not held");
   property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_busy: assert property (p_busy) else $error("write taken during response");
   property p_ack; irq_ack && irq_req |=> cpu_level == $past(irq_level); endproperty
   a_ack: assert property (p_ack) else $error("level not taken on ack");
   property p_trap; irq_req && irq_level > 4'h9 |-> irq_vector == 7'(4'hf - irq_level); endproperty
   a_trap: assert property (p_trap) else $error("trap level and vector differ");
   property p_slot; irq_req |-> irq_addr[7:0] == 8'h04 + {irq_vector, 1'b0} && irq_addr[23:9] == '0; endproperty
   a_slot: assert property (p_slot) else $error("vector slot address wrong");
   property p_osc; trap_evt[0] |-> ##2 irq_req && irq_vector == 7'h01; endproperty
   a_osc: assert property (p_osc) else $error("oscillator trap not presented");
   // Stale winners right after a level change are not judged
   property p_above; $stable(cpu_level) [*3] ##0 (irq_req && irq_level < 4'h8)
      |-> irq_level > cpu_level; endproperty
   a_above: assert property (p_above) else $error("user source at or below CPU level");
   property p_msb; !cpu_level[3] && !(irq_ack && irq_req) |=> !cpu_level[3]; endproperty
   a_msb: assert property (p_msb) else $error("level msb set by software");
endmodule : pvic_checker

// >>> pvic_cpu_model.sv
// CPU model: takes a presented interrupt after a set delay
`timescale 1ns/10ps
module pvic_cpu_model (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic en, // Taking interrupts
   input wire logic [3:0] dly, // Cycles before taking
   input wire logic irq_req, // Request
   output logic irq_ack // Taken pulse
);
   logic [3:0] wait_reg;
   // Wait restarts after each take, so a trap left pending is taken again
   always_ff @(posedge aclk) begin
      if (!aresetn || !en || !irq_req || irq_ack) begin
         wait_reg <= 4'h0;
         irq_ack <= 1'b0;
      end else begin
         wait_reg <= wait_reg + 4'h1;
         irq_ack <= wait_reg == dly;
      end
   end
endmodule : pvic_cpu_model

// >>> test_prioritized_vectored_interrupt_ctrl.sv
// Bench for the vectored interrupt controller
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module test_prioritized_vectored_interrupt_ctrl;
   import pvic_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, en = 1'b0;
   logic [3:0] dly = 4'h2, s_axi_wstrb = 4'hf, irq_level, cpu_level;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_ack, irq_req;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [NSRC-1:0] src_req = '0;
   logic [NTRAP-1:0] trap_evt = '0;
   logic [2:0] ext_irq = 3'h0;
   logic [5:0] m = 6'h00;
   logic [6:0] irq_vector;
   logic [23:0] irq_addr;
   logic [15:0] rd;
   int mismatches = 0, n_tests = 0;
   // Source index, priority, expected vector
   int rows [4][3] = '{'{0, 3, 8}, '{3, 5, 11}, '{20, 7, 28}, '{79, 1, 87}};
   always #2.5 aclk = ~aclk;
   pvic_ctrl pvic_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .src_req, .ext_irq, .trap_evt, .math_ovf_a(m[5]),
      .math_ovf_b(m[4]), .math_cat_a(m[3]), .math_cat_b(m[2]), .math_bad_shift(m[1]),
      .math_zero_div(m[0]), .irq_ack, .irq_req, .irq_vector, .irq_level, .irq_addr, .cpu_level);
   pvic_cpu_model pvic_cpu_model_i (.aclk, .aresetn, .en, .dly, .irq_req, .irq_ack);
   task automatic report_and_stop;
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic timeout;
      mismatches++;
      report_and_stop;
   endtask : timeout
   // ==========================================================
   // Bus master
   task automatic axi(input logic we, input logic [7:0] a, input logic [15:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {16'h0000, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {{3{we}}, {2{!we}}};
      for (int n = 0; n < 30; n++) begin
         @(posedge aclk);
         {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid && !s_axi_awready,
            s_axi_wvalid && !s_axi_wready, s_axi_arvalid && !s_axi_arready};
         if (we ? s_axi_bvalid : s_axi_rvalid) begin
            rsp = we ? s_axi_bresp : s_axi_rresp;
            rd = s_axi_rdata[15:0];
            {s_axi_bready, s_axi_rready} <= 2'b00;
            return;
         end
      end
      timeout;
   endtask : axi
   task automatic wirq(input logic v);
      int n;
      for (n = 0; n < 12 && irq_req !== v; n++) @(posedge aclk) #1;
      if (n == 12) timeout;
   endtask : wirq
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axi(0, GLOBAL_CTRL_ONE_OFS, 0);
      `CHK("ctl1", IC1_RESET, rd)
      axi(0, 8'hfc, 0);
      `CHK("resp", 2'b10, rsp)
      for (int i = 0; i < 4; i++) begin
         axi(1, 8'(SOURCE_ENABLE_BANK_OFS + rows[i][0] / 16 * 4), 16'(1 << rows[i][0] % 16));
         axi(1, 8'(SOURCE_PRIORITY_BANK_OFS + rows[i][0] / 4 * 4),
            16'(rows[i][1] << rows[i][0] % 4 * 4));
         src_req[rows[i][0]] <= 1'b1;
         @(posedge aclk) src_req <= '0;
         wirq(1'b1);
         `CHK("vec", 7'(rows[i][2]), irq_vector)
         `CHK("lvl", 4'(rows[i][1]), irq_level)
         `CHK("addr", 24'(4 + 2 * rows[i][2]), irq_addr)
         axi(0, PENDING_VECTOR_OFS, 0);
         `CHK("pend", 16'(rows[i][1] * 256 + rows[i][2]), rd)
         axi(1, 8'(REQUEST_FLAG_BANK_OFS + rows[i][0] / 16 * 4), 0);
         wirq(1'b0);
      end
      // Sources 1, 2 tie at 4; 3 flagged at 7, disabled
      axi(1, SOURCE_ENABLE_BANK_OFS, 16'h0006);
      axi(1, SOURCE_PRIORITY_BANK_OFS, 16'h7440);
      src_req[3:1] <= 3'h7;
      @(posedge aclk) src_req <= '0;
      wirq(1'b1);
      `CHK("tie", 7'h09, irq_vector)
      en <= 1'b1;
      wirq(1'b0);
      en <= 1'b0;
      `CHK("ack", 4'h4, cpu_level)
      axi(1, CPU_STATUS_WORD_OFS, 16'h0060);
      wirq(1'b1);
      axi(1, GLOBAL_CTRL_ONE_OFS, 16'h8000);
      axi(1, CPU_STATUS_WORD_OFS, 16'h00e0);
      `CHK("nest", 4'h3, cpu_level)
      axi(1, GLOBAL_CTRL_ONE_OFS, 0);
      axi(1, CPU_STATUS_WORD_OFS, 16'h00e0);
      wirq(1'b0);
      axi(1, CORE_CONTROL_WORD_OFS, 16'h0008);
      `CHK("msb", 4'h7, cpu_level)
      axi(1, GLOBAL_CTRL_TWO_OFS, 16'h8000);
      dly <= 4'h7;
      trap_evt <= 5'h01;
      @(posedge aclk) trap_evt <= '0;
      wirq(1'b1);
      `CHK("trap", 24'h000106, irq_addr)
      en <= 1'b1;
      for (int n = 0; n < 20 && cpu_level !== 4'he; n++) @(posedge aclk) #1;
      en <= 1'b0;
      `CHK("tlvl", 4'he, cpu_level)
      axi(1, CORE_CONTROL_WORD_OFS, 0);
      `CHK("clr", 4'h6, cpu_level)
      axi(1, GLOBAL_CTRL_ONE_OFS, 16'h0700);
      m <= 6'h3f;
      @(posedge aclk) m <= '0;
      axi(0, GLOBAL_CTRL_ONE_OFS, 0);
      `CHK("math", 16'h7fd0, rd)
      axi(1, GLOBAL_CTRL_ONE_OFS, 0);
      wirq(1'b0);
      report_and_stop;
   end
endmodule : test_prioritized_vectored_interrupt_ctrl
bind pvic_ctrl pvic_checker pvic_checker_i (.aclk, .aresetn, .s_axi_awready, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .trap_evt, .irq_ack, .irq_req, .irq_vector,
   .irq_level, .irq_addr, .cpu_level);
